//--- hw/rmsc_ctrl.sv
// Operation
// R1: ready about 650 us after shutdown release
// R2: power-on reset leads into ready
// R3: transmit by command or sleep wake pending
// R4: lock-for-transmit holds lock until next command
// R5: lock reached on detector or timeout
// R6: transmit lasts until done, underflow, abort; here underflow ends transmit only in direct mode
// R7: after transmit: transmit, protocol or ready
// R8: abort in transmit uses completion destinations
// R9: host sends marker byte then code
// R10: command acts at byte end, no cs rise
// R11: lock-for-transmit from ready enters lock
// R12: abort valid only in transmit
// R13: reload wakeup timer and sequence anytime
// R14: encryption and decryption starts anytime
// R15: key compute and key-then-decrypt anytime
// R16: soft reset equals power-on reset
// R17: internal reset low held fixed pulse
// R18: reset returns all state to defaults
// R19: timer period prescaler times counter
// R20: zero prescaler or counter never expires
// R21: host never writes zero wakeup values
// R22: wakeup timer on rc steps, value+1
// R23: stable states left only by command
// R24: invalid or unknown commands are ignored
`timescale 1ns/1ps
`default_nettype none
module rmsc_ctrl #(
  parameter int RESET_CYCLES   = rmsc_pkg::RESET_CYCLES,
  parameter int RC_STEP_CYCLES = rmsc_pkg::RC_STEP_CYCLES
) (
  // clock and power-on reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       shutdown_pin,
  // spi pins
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  input  wire logic       spi_cs_n,
  // synthesizer and timer settings
  input  wire logic       synth_lock,
  input  wire logic [7:0] lock_tmo_prescaler,
  input  wire logic [7:0] lock_tmo_counter,
  input  wire logic [7:0] wakeup_prescaler,
  input  wire logic [7:0] wakeup_counter,
  // transmit datapath and protocol
  input  wire logic       tx_pending,
  input  wire logic       tx_done,
  input  wire logic       tx_underflow,
  input  wire logic       direct_tx_mode,
  input  wire logic       persistent_tx,
  input  wire logic       protocol_active,
  input  wire logic       protocol_done,
  // status
  output logic [6:0]      state_code,
  output logic            internal_reset_low,
  output logic            synth_tx_cfg,
  output logic            lock_reached,
  // dispatched strobes
  output logic            seq_reload,
  output logic            aes_enc_start,
  output logic            aes_key_start,
  output logic            aes_dec_start,
  output logic            aes_keydec_start,
  output logic            tx_queue_clear
);
  localparam int RW = $clog2(RESET_CYCLES + 1);
  localparam int CW = $clog2(RC_STEP_CYCLES + 1);

  rmsc_pkg::rmsc_state_t state_q, state_d;
  logic          hold_q, hold_d;
  logic [RW-1:0] rcnt_q, rcnt_d;
  logic [6:0]    code_q, code_d;
  logic          rstn_q, rstn_d, lockr_q, lockr_d;
  logic [5:0]    strb_q, strb_d;
  logic [CW-1:0] rc_q, rc_d;
  logic          rc_step;
  logic          cmd_valid, lock_tmo_exp, wake_exp;
  logic [7:0]    cmd_code;
  logic          rx_rst, lock_load, wake_load, is_cmd, lock_evt;

  // destination after a transmit ends
  function automatic rmsc_pkg::rmsc_state_t tx_dest(input logic pers, input logic prot);
    if (pers)
      tx_dest = rmsc_pkg::ST_TX;
    else if (prot)
      tx_dest = rmsc_pkg::ST_PROTOCOL;
    else
      tx_dest = rmsc_pkg::ST_READY;
  endfunction

  // state code seen by software
  function automatic logic [6:0] st_code(input rmsc_pkg::rmsc_state_t s);
    case (s)
      rmsc_pkg::ST_READY:   st_code = rmsc_pkg::CODE_READY;
      rmsc_pkg::ST_STANDBY: st_code = rmsc_pkg::CODE_STANDBY;
      rmsc_pkg::ST_SLEEP:   st_code = rmsc_pkg::CODE_SLEEP;
      rmsc_pkg::ST_LOCK:    st_code = rmsc_pkg::CODE_LOCK;
      rmsc_pkg::ST_TX:      st_code = rmsc_pkg::CODE_TX;
      default:              st_code = rmsc_pkg::CODE_NONE;
    endcase
  endfunction

  // receiver is cleared whenever the part is off
  assign rx_rst = rst || shutdown_pin;

  rmsc_cmd_rx u_rx (
    .clk       (clk),
    .rst       (rx_rst),
    .spi_sclk  (spi_sclk),
    .spi_mosi  (spi_mosi),
    .spi_cs_n  (spi_cs_n),
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code)
  );

  rmsc_timer #(.PLUS_ONE(1'b0)) u_lock_tmo (
    .clk       (clk),
    .rst       (rst),
    .step      (1'b1),
    .load      (lock_load),
    .prescaler (lock_tmo_prescaler),
    .counter   (lock_tmo_counter),
    .expired   (lock_tmo_exp)
  );

  rmsc_timer #(.PLUS_ONE(1'b1)) u_wake (
    .clk       (clk),
    .rst       (rst),
    .step      (rc_step),
    .load      (wake_load),
    .prescaler (wakeup_prescaler),
    .counter   (wakeup_counter),
    .expired   (wake_exp)
  );

  // rc oscillator step as an enable pulse
  always_comb
  begin
    rc_step = (rc_q == CW'(RC_STEP_CYCLES - 1)); // R22
    rc_d    = rc_step ? '0 : rc_q + CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rc_q <= '0;
    else
      rc_q <= rc_d;
  end

  // main state machine and command dispatch
  always_comb
  begin
    state_d   = state_q;
    hold_d    = hold_q;
    rcnt_d    = rcnt_q;
    strb_d    = 6'h00;
    lock_load = 1'b0;
    wake_load = 1'b0;
    lockr_d   = lockr_q;
    is_cmd    = cmd_valid;
    lock_evt  = synth_lock || lock_tmo_exp; // R5
    if (shutdown_pin)
    begin
      state_d = rmsc_pkg::ST_SHUTDOWN;
      lockr_d = 1'b0;
    end
    else
    begin
      case (state_q)
        rmsc_pkg::ST_SHUTDOWN:
        begin
          // falling step on shutdown starts the reset pulse
          state_d = rmsc_pkg::ST_RESET; // R17
          rcnt_d  = RW'(RESET_CYCLES - 1);
        end
        rmsc_pkg::ST_RESET:
        begin
          if (rcnt_q == '0)
            state_d = rmsc_pkg::ST_READY; // R1 R2
          else
            rcnt_d = rcnt_q - RW'(1);
        end
        default:
        begin
          // transient behaviour of each state
          case (state_q)
            rmsc_pkg::ST_SLEEP:
              if (wake_exp)
              begin
                hold_d    = 1'b0;
                lock_load = tx_pending;
                state_d   = tx_pending ? rmsc_pkg::ST_LOCK : rmsc_pkg::ST_READY; // R3
              end
            rmsc_pkg::ST_LOCK:
              if (lock_evt)
              begin
                lockr_d = 1'b1;
                if (!hold_q)
                  state_d = rmsc_pkg::ST_TX; // R5
              end
            rmsc_pkg::ST_TX:
              if (tx_done || (direct_tx_mode && tx_underflow))
                state_d = tx_dest(persistent_tx, protocol_active); // R6 R7
            rmsc_pkg::ST_PROTOCOL:
              if (protocol_done)
                state_d = rmsc_pkg::ST_READY;
            default:
              state_d = state_q; // R23
          endcase
          // commands take precedence over transient events
          if (is_cmd)
          begin
            case (cmd_code)
              rmsc_pkg::CMD_TX:
                if (state_q == rmsc_pkg::ST_READY)
                begin
                  state_d   = rmsc_pkg::ST_LOCK; // R3
                  hold_d    = 1'b0;
                  lock_load = 1'b1;
                  lockr_d   = 1'b0;
                end
              rmsc_pkg::CMD_LOCK_TX:
                if (state_q == rmsc_pkg::ST_READY)
                begin
                  state_d   = rmsc_pkg::ST_LOCK; // R11
                  hold_d    = 1'b1; // R4
                  lock_load = 1'b1;
                  lockr_d   = 1'b0;
                end
              rmsc_pkg::CMD_READY:
                if (state_q == rmsc_pkg::ST_STANDBY || state_q == rmsc_pkg::ST_SLEEP
                    || state_q == rmsc_pkg::ST_LOCK)
                begin
                  state_d = rmsc_pkg::ST_READY;
                  lockr_d = 1'b0;
                end
              rmsc_pkg::CMD_STANDBY:
                if (state_q == rmsc_pkg::ST_READY)
                  state_d = rmsc_pkg::ST_STANDBY;
              rmsc_pkg::CMD_SLEEP:
                if (state_q == rmsc_pkg::ST_READY)
                begin
                  state_d   = rmsc_pkg::ST_SLEEP;
                  wake_load = 1'b1;
                end
              rmsc_pkg::CMD_ABORT_TX:
                if (state_q == rmsc_pkg::ST_TX) // R12
                  state_d = tx_dest(persistent_tx, protocol_active); // R8
              rmsc_pkg::CMD_WAKE_RELOAD: wake_load = 1'b1; // R13
              rmsc_pkg::CMD_SEQ_UPDATE:  strb_d[0] = 1'b1; // R13
              rmsc_pkg::CMD_AES_ENC:     strb_d[1] = 1'b1; // R14
              rmsc_pkg::CMD_AES_KEY:     strb_d[2] = 1'b1; // R15
              rmsc_pkg::CMD_AES_DEC:     strb_d[3] = 1'b1; // R14
              rmsc_pkg::CMD_AES_KEYDEC:  strb_d[4] = 1'b1; // R15
              rmsc_pkg::CMD_CLEAR_TXQ:   strb_d[5] = 1'b1;
              rmsc_pkg::CMD_SOFT_RESET:
              begin
                state_d = rmsc_pkg::ST_RESET; // R16
                rcnt_d  = RW'(RESET_CYCLES - 1);
                lockr_d = 1'b0;
                hold_d  = 1'b0;
              end
              default: state_d = state_d; // R24
            endcase
          end
        end
      endcase
    end
    if (state_d != rmsc_pkg::ST_LOCK && state_d != rmsc_pkg::ST_TX)
      lockr_d = 1'b0;
    rstn_d = (state_d != rmsc_pkg::ST_RESET && state_d != rmsc_pkg::ST_SHUTDOWN); // R17
    code_d = st_code(state_d);
  end

  // power-on reset holds the internal reset pulse as well
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= rmsc_pkg::ST_RESET; // R18
      hold_q  <= 1'b0;
      rcnt_q  <= RW'(RESET_CYCLES - 1);
      code_q  <= rmsc_pkg::CODE_NONE;
      rstn_q  <= 1'b0;
      lockr_q <= 1'b0;
      strb_q  <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      hold_q  <= hold_d;
      rcnt_q  <= rcnt_d;
      code_q  <= code_d;
      rstn_q  <= rstn_d;
      lockr_q <= lockr_d;
      strb_q  <= strb_d;
    end
  end

  assign state_code         = code_q;
  assign internal_reset_low = rstn_q;
  assign synth_tx_cfg       = (code_q == rmsc_pkg::CODE_LOCK) || (code_q == rmsc_pkg::CODE_TX);
  assign lock_reached       = lockr_q;
  assign seq_reload         = strb_q[0];
  assign aes_enc_start      = strb_q[1];
  assign aes_key_start      = strb_q[2];
  assign aes_dec_start      = strb_q[3];
  assign aes_keydec_start   = strb_q[4];
  assign tx_queue_clear     = strb_q[5];

  a_reset_to_ready: assert property (@(posedge clk) disable iff (rst) // R2
    state_q == rmsc_pkg::ST_RESET && rcnt_q == '0 && !shutdown_pin
    |=> state_code == rmsc_pkg::CODE_READY && internal_reset_low)
    else $error("reset end did not reach ready");
  a_reset_pulse_low: assert property (@(posedge clk) disable iff (rst) // R17
    $fell(shutdown_pin) |=> !internal_reset_low [*2])
    else $error("reset pulse not held after shutdown release");
  a_tx_cmd_lock: assert property (@(posedge clk) disable iff (rst) // R3
    state_q == rmsc_pkg::ST_READY && cmd_valid && cmd_code == rmsc_pkg::CMD_TX
    && !shutdown_pin |=> state_q == rmsc_pkg::ST_LOCK && !hold_q)
    else $error("transmit command did not enter lock");
  a_lock_hold: assert property (@(posedge clk) disable iff (rst) // R4
    state_q == rmsc_pkg::ST_LOCK && hold_q && !cmd_valid && !shutdown_pin
    |=> state_q == rmsc_pkg::ST_LOCK)
    else $error("held lock advanced without command");
  a_lock_to_tx: assert property (@(posedge clk) disable iff (rst) // R5
    state_q == rmsc_pkg::ST_LOCK && !hold_q && synth_lock && !cmd_valid && !shutdown_pin
    |=> state_code == rmsc_pkg::CODE_TX && lock_reached)
    else $error("lock detect did not start transmit");
  a_tx_persists: assert property (@(posedge clk) disable iff (rst) // R6
    state_q == rmsc_pkg::ST_TX && !tx_done && !tx_underflow && !cmd_valid && !shutdown_pin
    |=> state_q == rmsc_pkg::ST_TX)
    else $error("transmit left without cause");
  a_tx_done_dest: assert property (@(posedge clk) disable iff (rst) // R7
    state_q == rmsc_pkg::ST_TX && tx_done && !persistent_tx && protocol_active
    && !cmd_valid && !shutdown_pin |=> state_q == rmsc_pkg::ST_PROTOCOL)
    else $error("transmit end went to wrong state");
  a_abort_ready: assert property (@(posedge clk) disable iff (rst) // R8
    state_q == rmsc_pkg::ST_TX && cmd_valid && cmd_code == rmsc_pkg::CMD_ABORT_TX
    && !persistent_tx && !protocol_active && !shutdown_pin
    |=> state_code == rmsc_pkg::CODE_READY)
    else $error("abort did not return to ready");
  a_soft_reset: assert property (@(posedge clk) disable iff (rst) // R16
    state_q == rmsc_pkg::ST_READY && cmd_valid && cmd_code == rmsc_pkg::CMD_SOFT_RESET
    && !shutdown_pin |=> !internal_reset_low && rcnt_q == RW'(RESET_CYCLES - 1))
    else $error("soft reset did not start reset pulse");
  a_aes_strobe: assert property (@(posedge clk) disable iff (rst) // R14
    cmd_valid && cmd_code == rmsc_pkg::CMD_AES_ENC && !shutdown_pin
    && state_q != rmsc_pkg::ST_RESET && state_q != rmsc_pkg::ST_SHUTDOWN
    |=> aes_enc_start ##1 !aes_enc_start)
    else $error("encryption strobe wrong");
  a_ignore_cmd: assert property (@(posedge clk) disable iff (rst) // R24
    state_q == rmsc_pkg::ST_READY && cmd_valid && cmd_code == rmsc_pkg::CMD_ABORT_TX
    && !shutdown_pin |=> state_q == rmsc_pkg::ST_READY)
    else $error("invalid command changed state");
endmodule
`default_nettype wire

//--- hw/rmsc_pkg.sv
`default_nettype none
package rmsc_pkg;
  // command framing and codes
  localparam logic [7:0] CMD_MARKER      = 8'h80;
  localparam logic [7:0] CMD_TX          = 8'h60;
  localparam logic [7:0] CMD_READY       = 8'h62;
  localparam logic [7:0] CMD_STANDBY     = 8'h63;
  localparam logic [7:0] CMD_SLEEP       = 8'h64;
  localparam logic [7:0] CMD_LOCK_TX     = 8'h66;
  localparam logic [7:0] CMD_ABORT_TX    = 8'h67;
  localparam logic [7:0] CMD_WAKE_RELOAD = 8'h68;
  localparam logic [7:0] CMD_SEQ_UPDATE  = 8'h69;
  localparam logic [7:0] CMD_AES_ENC     = 8'h6a;
  localparam logic [7:0] CMD_AES_KEY     = 8'h6b;
  localparam logic [7:0] CMD_AES_DEC     = 8'h6c;
  localparam logic [7:0] CMD_AES_KEYDEC  = 8'h6d;
  localparam logic [7:0] CMD_SOFT_RESET  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_TXQ   = 8'h72;

  // reported state codes
  localparam logic [6:0] CODE_NONE    = 7'h00;
  localparam logic [6:0] CODE_STANDBY = 7'h40;
  localparam logic [6:0] CODE_SLEEP   = 7'h36;
  localparam logic [6:0] CODE_READY   = 7'h03;
  localparam logic [6:0] CODE_LOCK    = 7'h0f;
  localparam logic [6:0] CODE_TX      = 7'h5f;

  // timing
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real T_RESET_MS    = 0.65;
  localparam real RC_STEP_US    = 29.0;
  localparam int  RESET_CYCLES  = $rtoi(T_RESET_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  RC_STEP_CYCLES = $rtoi(RC_STEP_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int  SPI_BITS      = 8;

  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_RESET, ST_READY, ST_STANDBY, ST_SLEEP, ST_LOCK, ST_TX, ST_PROTOCOL
  } rmsc_state_t;
endpackage
`default_nettype wire

//--- hw/rmsc_cmd_rx.sv
`timescale 1ns/1ps
`default_nettype none
module rmsc_cmd_rx (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // spi pins, sampled as synchronous
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  input  wire logic       spi_cs_n,
  // decoded command
  output logic            cmd_valid,
  output logic [7:0]      cmd_code
);
  logic       sclk_q, sclk_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] bit_q, bit_d;
  logic       armed_q, armed_d;
  logic       valid_q, valid_d;
  logic [7:0] code_q, code_d;
  logic [7:0] byte_w;

  // shift on sclk rise; marker byte arms, next byte is the code
  always_comb
  begin
    byte_w  = {shift_q[6:0], spi_mosi};
    sclk_d  = spi_sclk;
    shift_d = shift_q;
    bit_d   = bit_q;
    armed_d = armed_q;
    valid_d = 1'b0;
    code_d  = code_q;
    if (spi_cs_n)
    begin
      bit_d   = 3'h0;
      armed_d = 1'b0;
    end
    else if (spi_sclk && !sclk_q)
    begin
      shift_d = byte_w;
      bit_d   = bit_q + 3'h1;
      if (bit_q == 3'(rmsc_pkg::SPI_BITS - 1))
      begin
        // command acts at byte end, cs need not rise
        if (armed_q)
        begin
          valid_d = 1'b1; // R10
          code_d  = byte_w;
          armed_d = 1'b0;
        end
        else
          armed_d = (byte_w == rmsc_pkg::CMD_MARKER); // R9
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclk_q  <= 1'b0;
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
      armed_q <= 1'b0;
      valid_q <= 1'b0;
      code_q  <= 8'h00;
    end
    else
    begin
      sclk_q  <= sclk_d;
      shift_q <= shift_d;
      bit_q   <= bit_d;
      armed_q <= armed_d;
      valid_q <= valid_d;
      code_q  <= code_d;
    end
  end

  assign cmd_valid = valid_q;
  assign cmd_code  = code_q;
endmodule
`default_nettype wire

//--- hw/rmsc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rmsc_timer #(
  parameter bit PLUS_ONE = 1'b0
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       step,
  input  wire logic       load,
  input  wire logic [7:0] prescaler,
  input  wire logic [7:0] counter,
  // status
  output logic            expired
);
  logic [8:0] pre_q, pre_d, cnt_q, cnt_d;
  logic       act_q, act_d, exp_q, exp_d;
  logic [8:0] pre_lim, cnt_lim;

  // period is prescaler x counter steps; zero never expires unless plus-one
  always_comb
  begin
    pre_lim = {1'b0, prescaler} + {8'h00, PLUS_ONE}; // R22
    cnt_lim = {1'b0, counter} + {8'h00, PLUS_ONE};
    pre_d   = pre_q;
    cnt_d   = cnt_q;
    act_d   = act_q;
    exp_d   = 1'b0;
    if (load)
    begin
      pre_d = 9'h000;
      cnt_d = 9'h000;
      act_d = 1'b1;
    end
    else if (step && act_q && pre_lim != 9'h000 && cnt_lim != 9'h000) // R20
    begin
      pre_d = pre_q + 9'h001;
      if (pre_q == pre_lim - 9'h001) // R19
      begin
        pre_d = 9'h000;
        cnt_d = cnt_q + 9'h001;
        if (cnt_q == cnt_lim - 9'h001)
        begin
          exp_d = 1'b1;
          act_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_q <= 9'h000;
      cnt_q <= 9'h000;
      act_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      act_q <= act_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule
`default_nettype wire

//--- tb/rmsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: sends bytes msb first, four clk cycles per spi bit
module rmsc_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // byte request
  input  wire logic       go,
  input  wire logic [7:0] data,
  input  wire logic       keep_cs,
  output logic            busy,
  // spi pins
  output logic            spi_sclk,
  output logic            spi_mosi,
  output logic            spi_cs_n
);
  logic [7:0] sh_q;
  logic [4:0] ph_q;

  // one byte per request; slow sclk keeps every bit visible to the sampler
  always @(posedge clk)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      spi_sclk <= 1'b0;
      spi_mosi <= 1'b0;
      spi_cs_n <= 1'b1;
      sh_q     <= 8'h00;
      ph_q     <= 5'h00;
    end
    else if (!busy && go)
    begin
      busy     <= 1'b1;
      spi_cs_n <= 1'b0;
      spi_mosi <= data[7];
      sh_q     <= data;
      ph_q     <= 5'h00;
    end
    else if (busy)
    begin
      ph_q <= ph_q + 5'h01;
      if (ph_q[1:0] == 2'h1)
        spi_sclk <= 1'b1;
      if (ph_q[1:0] == 2'h3)
      begin
        spi_sclk <= 1'b0;
        // a released line must not keep showing the last bit
        spi_mosi <= (ph_q == 5'h1f && !keep_cs) ? ~sh_q[7] : sh_q[6];
        sh_q     <= {sh_q[6:0], 1'b0};
      end
      if (ph_q == 5'h1f)
      begin
        busy <= 1'b0;
        if (!keep_cs)
          spi_cs_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_radio_mode_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_radio_mode_state_controller;
  logic clk, rst, shutdown_pin, spi_sclk, spi_mosi, spi_cs_n, synth_lock;
  logic tx_pending, tx_done, tx_underflow, direct_tx_mode, persistent_tx;
  logic protocol_active, protocol_done, internal_reset_low, synth_tx_cfg, lock_reached;
  logic seq_reload, aes_enc_start, aes_key_start, aes_dec_start, aes_keydec_start;
  logic tx_queue_clear, go, keep, busy, clr;
  logic [7:0] lock_tmo_prescaler, lock_tmo_counter, wakeup_prescaler, wakeup_counter, dat;
  logic [6:0] state_code;
  logic [6:0] dest [3];
  logic [7:0] codes [7];
  logic [5:0] seen_q;
  int failures, compares, n, k;

  rmsc_ctrl #(.RESET_CYCLES(20), .RC_STEP_CYCLES(4)) i_dut (.clk, .rst, .shutdown_pin,
    .spi_sclk, .spi_mosi, .spi_cs_n, .synth_lock, .lock_tmo_prescaler, .lock_tmo_counter,
    .wakeup_prescaler, .wakeup_counter, .tx_pending, .tx_done, .tx_underflow,
    .direct_tx_mode, .persistent_tx, .protocol_active, .protocol_done, .state_code,
    .internal_reset_low, .synth_tx_cfg, .lock_reached, .seq_reload, .aes_enc_start,
    .aes_key_start, .aes_dec_start, .aes_keydec_start, .tx_queue_clear);

  rmsc_host_model i_host (.clk, .rst, .go, .data(dat), .keep_cs(keep), .busy, .spi_sclk,
    .spi_mosi, .spi_cs_n);

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // strobes are one cycle wide, so catch them as they pass
  always @(posedge clk)
    seen_q <= clr ? 6'h00 : seen_q | {tx_queue_clear, aes_keydec_start, aes_dec_start,
      aes_key_start, aes_enc_start, seq_reload};

  task automatic results();
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bad(string m);
    failures++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic chk_state(logic [6:0] exp);
    compares++;
    if (state_code !== exp)
      bad("state code");
  endtask

  task automatic chk_flags(logic [5:0] got, logic [5:0] exp, string m);
    compares++;
    if (got !== exp)
      bad(m);
  endtask

  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // bounded wait for a state; a hang ends the run
  task automatic wait_state(logic [6:0] exp, int lim);
    for (int i = 0; i < lim && state_code !== exp; i++)
      tick(1);
    if (state_code !== exp)
    begin
      bad("state timeout");
      results();
    end
  endtask

  task automatic byte_tx(logic [7:0] b, logic kc);
    @(posedge clk);
    go <= 1'b1;
    dat <= b;
    keep <= kc;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 100 && (i == 0 || busy); i++)
      tick(1);
    if (busy !== 1'b0)
    begin
      bad("spi hang");
      results();
    end
  endtask

  // marker then code; cs may stay low afterwards
  task automatic cmd(logic [7:0] c, logic kc);
    byte_tx(rmsc_pkg::CMD_MARKER, 1'b1);
    byte_tx(c, kc);
    tick(4);
  endtask

  task automatic pulse_done(logic prot);
    @(posedge clk);
    if (prot)
      protocol_done <= 1'b1;
    else
      tx_done <= 1'b1;
    @(posedge clk);
    protocol_done <= 1'b0;
    tx_done <= 1'b0;
    tick(3);
  endtask

  // watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    bad("run limit");
    results();
  end

  initial
  begin
    {shutdown_pin, tx_pending, tx_done, tx_underflow, direct_tx_mode, go, keep} = '0;
    {persistent_tx, protocol_active, protocol_done, clr} = '0;
    synth_lock = 1'b1;
    dat = 8'h00;
    lock_tmo_prescaler = 8'h02;
    lock_tmo_counter = 8'h03;
    wakeup_prescaler = 8'h03;
    wakeup_counter = 8'h03;
    dest = '{rmsc_pkg::CODE_READY, rmsc_pkg::CODE_NONE, rmsc_pkg::CODE_TX};
    codes = '{8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h72};
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk_flags(internal_reset_low, 1'b0, "reset pulse");
    chk_state(rmsc_pkg::CODE_NONE);
    wait_state(rmsc_pkg::CODE_READY, 100);
    // stray code byte, then a command not valid in ready
    byte_tx(rmsc_pkg::CMD_TX, 1'b1);
    cmd(rmsc_pkg::CMD_ABORT_TX, 1'b1);
    chk_state(rmsc_pkg::CODE_READY);
    cmd(rmsc_pkg::CMD_STANDBY, 1'b1);
    chk_state(rmsc_pkg::CODE_STANDBY);
    cmd(rmsc_pkg::CMD_TX, 1'b1);
    chk_state(rmsc_pkg::CODE_STANDBY);
    cmd(rmsc_pkg::CMD_READY, 1'b0);
    chk_state(rmsc_pkg::CODE_READY);
    cmd(rmsc_pkg::CMD_LOCK_TX, 1'b1);
    tick(40);
    chk_state(rmsc_pkg::CODE_LOCK);
    chk_flags({synth_tx_cfg, lock_reached}, 6'h3, "lock flags");
    cmd(rmsc_pkg::CMD_READY, 1'b1);
    chk_state(rmsc_pkg::CODE_READY);
    // each completion destination, abort in mid-transmit last
    for (n = 0; n < 3; n++)
    begin
      @(posedge clk);
      protocol_active <= (n == 1);
      persistent_tx <= (n == 2);
      cmd(rmsc_pkg::CMD_TX, 1'b1);
      wait_state(rmsc_pkg::CODE_TX, 50);
      pulse_done(1'b0);
      chk_state(dest[n]);
      // protocol state only ends on its own done pulse
      if (n == 1)
      begin
        pulse_done(1'b1);
        chk_state(rmsc_pkg::CODE_READY);
      end
    end
    cmd(rmsc_pkg::CMD_ABORT_TX, 1'b1);
    chk_state(rmsc_pkg::CODE_TX);
    @(posedge clk);
    persistent_tx <= 1'b0;
    protocol_active <= 1'b0;
    cmd(rmsc_pkg::CMD_ABORT_TX, 1'b1);
    chk_state(rmsc_pkg::CODE_READY);
    // lock by timeout, then underflow only counts in direct mode
    @(posedge clk);
    synth_lock <= 1'b0;
    cmd(rmsc_pkg::CMD_TX, 1'b1);
    chk_flags(lock_reached, 1'b0, "early lock");
    wait_state(rmsc_pkg::CODE_TX, 40);
    @(posedge clk);
    tx_underflow <= 1'b1;
    tick(5);
    chk_state(rmsc_pkg::CODE_TX);
    @(posedge clk);
    direct_tx_mode <= 1'b1;
    tick(4);
    chk_state(rmsc_pkg::CODE_READY);
    @(posedge clk);
    tx_underflow <= 1'b0;
    direct_tx_mode <= 1'b0;
    lock_tmo_prescaler <= 8'h00;
    cmd(rmsc_pkg::CMD_TX, 1'b1);
    tick(60);
    chk_state(rmsc_pkg::CODE_LOCK);
    cmd(rmsc_pkg::CMD_READY, 1'b1);
    chk_state(rmsc_pkg::CODE_READY);
    // dispatched strobes, reload first with no strobe
    for (n = 0; n < 7; n++)
    begin
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      cmd(codes[n], 1'b1);
      chk_flags(seen_q, (n == 0) ? 6'h00 : 6'h01 << (n - 1), "strobe");
    end
    chk_state(rmsc_pkg::CODE_READY);
    // wake from sleep with a pending transmit: 16 steps of 4 cycles
    @(posedge clk);
    synth_lock <= 1'b1;
    lock_tmo_prescaler <= 8'h02;
    tx_pending <= 1'b1;
    cmd(rmsc_pkg::CMD_SLEEP, 1'b1);
    tick(46);
    chk_state(rmsc_pkg::CODE_SLEEP);
    wait_state(rmsc_pkg::CODE_TX, 100);
    @(posedge clk);
    tx_pending <= 1'b0;
    pulse_done(1'b0);
    chk_state(rmsc_pkg::CODE_READY);
    cmd(rmsc_pkg::CMD_SOFT_RESET, 1'b0);
    chk_flags(internal_reset_low, 1'b0, "soft reset");
    wait_state(rmsc_pkg::CODE_READY, 100);
    // shutdown and release
    @(posedge clk);
    shutdown_pin <= 1'b1;
    tick(3);
    chk_state(rmsc_pkg::CODE_NONE);
    chk_flags(internal_reset_low, 1'b0, "shutdown reset");
    @(posedge clk);
    shutdown_pin <= 1'b0;
    k = 0;
    for (int i = 0; i < 100 && internal_reset_low !== 1'b1; i++)
    begin
      tick(1);
      k++;
    end
    chk_flags(k >= 20 && k <= 24, 1'b1, "pulse width");
    chk_state(rmsc_pkg::CODE_READY);
    results();
  end
endmodule
`default_nettype wire
